// ---- core/rlm_pkg.sv ----
// Shared constants for the relay line monitor: register map, field layout,
// reset values and timing figures.
// Assumes a single 200 MHz system clock; all counts are derived from it here.
package rlm_pkg;

   // Number of field channels on one relay board.
   localparam int unsigned NUM_CHANNELS = 7;

   // Clock rate, used to turn times into cycle counts.
   localparam int unsigned CLK_FREQ_MHZ = 200;

   // Oscillator half period in microseconds; each range phase lasts this long.
   localparam int unsigned OSC_HALF_PERIOD_US = 500;
   // Oscillator half period in clock cycles.
   localparam int unsigned OSC_HALF_CYCLES = OSC_HALF_PERIOD_US * CLK_FREQ_MHZ;

   // Power-up stabilisation time in milliseconds.
   localparam int unsigned POWER_DELAY_MS = 1000;
   // Power-up stabilisation time in clock cycles.
   localparam int unsigned POWER_DELAY_CYCLES = POWER_DELAY_MS * 1000 * CLK_FREQ_MHZ;

   // Digital input positions (input n sits at bit n-1).
   localparam int unsigned DIN_VOLT_BASE = 0;
   localparam int unsigned DIN_POWER_GOOD = 7;
   localparam int unsigned DIN_CURR_BASE = 8;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] REG_CONTROL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_FAULTS = 12'h008;
   localparam logic [11:0] REG_RELAYS = 12'h00C;

   // Field positions inside the control register.
   localparam int unsigned CTRL_CMD_LSB = 0;
   localparam int unsigned CTRL_INUSE_LSB = 8;
   // Field positions inside the status register.
   localparam int unsigned STAT_HEALTHY_LSB = 0;
   localparam int unsigned STAT_MODULE_BIT = 7;
   localparam int unsigned STAT_VALID_BIT = 8;
   localparam int unsigned STAT_RANGE_BIT = 9;
   // Field positions inside the fault register.
   localparam int unsigned FLT_SHORT_LSB = 0;
   localparam int unsigned FLT_OPEN_LSB = 8;
   localparam int unsigned FLT_MISMATCH_LSB = 16;

   // Values after reset.
   localparam logic [6:0] CMD_RESET = 7'h00;
   localparam logic [6:0] INUSE_RESET = 7'h00;

endpackage

// ---- core/rlm_channel.sv ----
// One channel of the relay line monitor: relay drive, readback latches and
// the short, open and mismatch evaluation.
// Assumes latchTick comes from the shared oscillator and rangePhase is the
// range that was applied during the phase which that tick closes.
`timescale 1ns/1ps
module rlm_channel (
   input wire logic clk,
   input wire logic rst,
   input wire logic resultsValid,
   input wire logic latchTick,
   input wire logic rangePhase,
   input wire logic commandedValue,
   input wire logic inUse,
   input wire logic voltageReadback,
   input wire logic currentReadback,
   output logic relayOut,
   output logic shortFault,
   output logic openFault,
   output logic feedbackMismatch,
   output logic channelHealthy
);

   logic relay_ff; // Registered relay drive.
   logic short_ff; // Short detected in the last low-range phase.
   logic open_ff; // Open line or blown fuse detected.
   logic mismatch_ff; // Field state disagrees with the relay.
   logic stable_ff; // Relay held still for the whole current phase.
   logic checkPhase; // The closing phase is usable for evaluation.

   // A phase in which the relay moved carries mixed readback, so it is skipped.
   assign checkPhase = latchTick && stable_ff && resultsValid;

   // Relay follows the command unless a short holds it off.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         relay_ff <= 1'b0;
      end else begin
         relay_ff <= commandedValue && !short_ff;
      end
   end

   // Stability tracker: armed at every tick, dropped when the relay changes.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stable_ff <= 1'b0;
      end else if (latchTick) begin
         stable_ff <= 1'b1;
      end else if (relay_ff != (commandedValue && !short_ff)) begin
         stable_ff <= 1'b0;
      end
   end

   // Fault evaluation on latched readback. Low range judges short, fuse and
   // mismatch; high range judges the off-state open line.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         short_ff <= 1'b0;
         open_ff <= 1'b0;
         mismatch_ff <= 1'b0;
      end else if (!resultsValid) begin
         // Results are meaningless until the field supply has settled.
         short_ff <= 1'b0;
         open_ff <= 1'b0;
         mismatch_ff <= 1'b0;
      end else if (checkPhase && !rangePhase) begin
         if (relay_ff) begin
            // No current while energised means broken lead or blown fuse.
            open_ff <= !currentReadback;
            mismatch_ff <= !voltageReadback;
         end else begin
            // Field voltage not lifted over the low threshold means a short.
            short_ff <= !voltageReadback;
            mismatch_ff <= currentReadback;
         end
      end else if (checkPhase && rangePhase && !relay_ff) begin
         // Injection resistor lifting the line over the reference: open line.
         open_ff <= voltageReadback;
      end
   end

   assign relayOut = relay_ff;
   assign shortFault = short_ff;
   // Spare channels never show an open line.
   assign openFault = open_ff && inUse;
   assign feedbackMismatch = mismatch_ff;
   assign channelHealthy = resultsValid && !short_ff && !openFault && !mismatch_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_short_blocks;
      shortFault |=> !relayOut;
   endproperty
   a_short_blocks: assert property (p_short_blocks) else $error("Relay on during short.");

   property p_relay_follows;
      commandedValue && !shortFault |=> relayOut;
   endproperty
   a_relay_follows: assert property (p_relay_follows) else $error("Relay ignored command.");

   property p_no_fault_invalid;
      !resultsValid |=> !shortFault && !openFault && !feedbackMismatch;
   endproperty
   a_no_fault_invalid: assert property (p_no_fault_invalid) else $error("Fault while invalid.");

   property p_spare_quiet;
      !inUse |-> !openFault;
   endproperty
   a_spare_quiet: assert property (p_spare_quiet) else $error("Open on spare channel.");

   property p_healthy_clean;
      channelHealthy |-> !shortFault && !openFault && !feedbackMismatch && resultsValid;
   endproperty
   a_healthy_clean: assert property (p_healthy_clean) else $error("Healthy with fault.");

   property p_short_detect;
      latchTick && stable_ff && resultsValid && !rangePhase && !relayOut && !voltageReadback
         |=> shortFault || !resultsValid;
   endproperty
   a_short_detect: assert property (p_short_detect) else $error("Short missed.");

   property p_open_on;
      latchTick && stable_ff && resultsValid && !rangePhase && relayOut && !currentReadback
         && inUse |=> openFault || !resultsValid || !inUse;
   endproperty
   a_open_on: assert property (p_open_on) else $error("Open while on missed.");

   property p_open_off;
      latchTick && stable_ff && resultsValid && rangePhase && !relayOut && voltageReadback
         && inUse |=> openFault || !resultsValid || !inUse;
   endproperty
   a_open_off: assert property (p_open_off) else $error("Open while off missed.");

   c_short: cover property (!shortFault ##1 shortFault);
   c_open: cover property (!openFault ##1 openFault);
   c_mismatch: cover property (!feedbackMismatch ##1 feedbackMismatch);

endmodule

// ---- core/rlm_relay_line_monitor.sv ----
// Top of the relay line monitor: shared oscillator, power-up delay, seven
// channel blocks, module-healthy AND and an APB register slave.
// Assumes digital inputs are synchronous to clk and APB runs on the same clock.
//
// Notes on behaviour
// - Off channel, voltage above reference: open.
// - On channel, no current: open.
// - Unused channel never reports open.
// - Off channel, voltage below low threshold: short.
// - Blown fuse reported as open line.
// - Oscillator toggles range and clocks latches.
// - One oscillator may serve several boards; here each instance runs its own and has no tick or range input.
// - Results invalid until power settles.
// - Module healthy is AND of channels.
// - Short fault blocks relay energisation.
// - Open output flags breakage or fuse.
// - Mismatch when field disagrees with relay.
// - Channel healthy only without any fault.
// - Relay driven from commanded value.
// - Voltage readback from inputs one to seven.
// - Current readback from inputs nine to fifteen.
// - Input eight is power good; sixteen unused.
`timescale 1ns/1ps
module rlm_relay_line_monitor #(
   parameter int unsigned OSC_HALF_CYCLES = rlm_pkg::OSC_HALF_CYCLES,
   parameter int unsigned POWER_DELAY_CYCLES = rlm_pkg::POWER_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] digitalIn,
   output logic [6:0] relayOut,
   output logic rangeSelect,
   output logic oscTick,
   output logic [6:0] shortFault,
   output logic [6:0] openFault,
   output logic [6:0] feedbackMismatch,
   output logic [6:0] channelHealthy,
   output logic moduleHealthy,
   output logic resultsValid
);

   localparam int unsigned NCH = rlm_pkg::NUM_CHANNELS;

   logic [31:0] oscCount_ff; // Oscillator phase counter.
   logic range_ff; // Current range select level.
   logic [31:0] delayCount_ff; // Power-up stabilisation counter.
   logic valid_ff; // Line monitoring results may be used.
   logic [6:0] command_ff; // Commanded values from software.
   logic [6:0] inUse_ff; // Channel in-use flags from software.
   logic [31:0] rdata_ff; // Registered read data.
   logic err_ff; // Registered error answer.
   logic powerGood; // Field supply present.
   logic [6:0] voltageReadback; // Per-channel voltage results.
   logic [6:0] currentReadback; // Per-channel current results.
   logic setupPhase; // APB setup cycle.
   logic accessPhase; // APB access cycle.
   logic hitControl; // Address selects the control register.
   logic hitStatus; // Address selects the status register.
   logic hitFaults; // Address selects the fault register.
   logic hitRelays; // Address selects the relay register.
   logic addrHit; // Address is mapped.
   logic [31:0] statusWord; // Assembled status view.
   logic [31:0] faultWord; // Assembled fault view.
   logic [31:0] readMux; // Selected read value.

   // Input mapping; input n sits at bit n-1 and input sixteen is ignored.
   assign voltageReadback = digitalIn[rlm_pkg::DIN_VOLT_BASE +: NCH];
   assign currentReadback = digitalIn[rlm_pkg::DIN_CURR_BASE +: NCH];
   assign powerGood = digitalIn[rlm_pkg::DIN_POWER_GOOD];

   // The tick closes a phase, so readback has had a full half period to settle.
   assign oscTick = (oscCount_ff == 32'(OSC_HALF_CYCLES - 1));

   // Free-running oscillator. The tick and range are also ports, but every instance
   // runs its own oscillator and has no input to take another board's tick or range.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oscCount_ff <= 32'h00000000;
         range_ff <= 1'b0;
      end else if (oscTick) begin
         oscCount_ff <= 32'h00000000;
         range_ff <= !range_ff;
      end else begin
         oscCount_ff <= oscCount_ff + 32'h00000001;
      end
   end

   // Power-up delay: counting restarts whenever the field supply drops, and
   // results are withdrawn at once rather than after a delay.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delayCount_ff <= 32'h00000000;
         valid_ff <= 1'b0;
      end else if (!powerGood) begin
         delayCount_ff <= 32'h00000000;
         valid_ff <= 1'b0;
      end else if (delayCount_ff == 32'(POWER_DELAY_CYCLES - 1)) begin
         valid_ff <= 1'b1;
      end else begin
         delayCount_ff <= delayCount_ff + 32'h00000001;
      end
   end

   // One channel block per field channel.
   for (genvar ch = 0; ch < NCH; ch++) begin : g_channel
      rlm_channel u_channel (
         .clk(clk),
         .rst(rst),
         .resultsValid(valid_ff),
         .latchTick(oscTick),
         .rangePhase(range_ff),
         .commandedValue(command_ff[ch]),
         .inUse(inUse_ff[ch]),
         .voltageReadback(voltageReadback[ch]),
         .currentReadback(currentReadback[ch]),
         .relayOut(relayOut[ch]),
         .shortFault(shortFault[ch]),
         .openFault(openFault[ch]),
         .feedbackMismatch(feedbackMismatch[ch]),
         .channelHealthy(channelHealthy[ch])
      );
   end

   // The whole board is healthy only if every channel is.
   assign moduleHealthy = &channelHealthy;
   assign rangeSelect = range_ff;
   assign resultsValid = valid_ff;

   // APB decode. The slave never waits: every access completes in one cycle.
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign hitControl = (paddr == rlm_pkg::REG_CONTROL);
   assign hitStatus = (paddr == rlm_pkg::REG_STATUS);
   assign hitFaults = (paddr == rlm_pkg::REG_FAULTS);
   assign hitRelays = (paddr == rlm_pkg::REG_RELAYS);
   assign addrHit = hitControl || hitStatus || hitFaults || hitRelays;

   // Status and fault views; unused bits read as zero.
   assign statusWord = {22'h000000, range_ff, valid_ff, moduleHealthy, channelHealthy};
   assign faultWord = {9'h000, feedbackMismatch, 1'b0, openFault, 1'b0, shortFault};

   // Read selection; an unmapped address reads zero.
   assign readMux = hitControl ? {17'h00000, inUse_ff, 1'b0, command_ff} :
                    hitStatus ? statusWord :
                    hitFaults ? faultWord :
                    hitRelays ? {25'h0000000, relayOut} : 32'h00000000;

   // Control register; only a completed write to it changes the commands.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         command_ff <= rlm_pkg::CMD_RESET;
         inUse_ff <= rlm_pkg::INUSE_RESET;
      end else if (accessPhase && pwrite && hitControl) begin
         command_ff <= pwdata[rlm_pkg::CTRL_CMD_LSB +: 7];
         inUse_ff <= pwdata[rlm_pkg::CTRL_INUSE_LSB +: 7];
      end
   end

   // Read data and error are captured in the setup cycle so that they come
   // from flip-flops yet are ready in the single access cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h00000000;
         err_ff <= 1'b0;
      end else if (setupPhase) begin
         rdata_ff <= pwrite ? 32'h00000000 : readMux;
         err_ff <= !addrHit;
      end
   end

   assign prdata = rdata_ff;
   assign pready = 1'b1;
   assign pslverr = accessPhase && err_ff;

   default clocking cbt @(posedge clk); endclocking
   default disable iff (rst);

   property p_module_and;
      moduleHealthy |-> (&channelHealthy) && valid_ff;
   endproperty
   a_module_and: assert property (p_module_and) else $error("Module healthy wrong.");

   property p_range_steady;
      !oscTick |=> $stable(rangeSelect);
   endproperty
   a_range_steady: assert property (p_range_steady) else $error("Range moved off tick.");

   property p_range_flip;
      oscTick |=> rangeSelect != $past(rangeSelect);
   endproperty
   a_range_flip: assert property (p_range_flip) else $error("Range did not toggle.");

   property p_power_loss;
      !digitalIn[7] |=> !resultsValid;
   endproperty
   a_power_loss: assert property (p_power_loss) else $error("Valid without power.");

   property p_unmapped;
      setupPhase && !addrHit ##1 accessPhase |-> pslverr && prdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped not refused.");

   c_valid: cover property (!resultsValid ##1 resultsValid);
   c_module_ok: cover property (moduleHealthy && |relayOut);

endmodule

// ---- verification/rlm_field_board.sv ----
// Behavioural model of the field side of the relay board: readback levels.
// Assumes the bench picks each channel's wiring condition through faultMode.
`timescale 1ns/1ps
module rlm_field_board (
   input wire logic clk,
   input wire logic [6:0] relayOut,
   input wire logic rangeSelect,
   input wire logic fieldPowerGood,
   input wire logic [13:0] faultMode,
   output logic [15:0] digitalIn
);
   // The spare input toggles every cycle, so a design that used it would show it.
   logic spareToggle = 1'h0;

   // Free toggle for the unused input.
   always @(posedge clk) begin
      spareToggle <= ~spareToggle;
   end

   // Modes: 0 healthy load, 1 short, 2 broken lead or fuse, 3 field fed from outside.
   always_comb begin
      logic [1:0] m;
      m = 2'h0;
      for (int i = 0; i < 7; i++) begin
         m = faultMode[2*i +: 2];
         // A healthy off load sits above the low threshold only in range 0.
         if (relayOut[i]) begin
            digitalIn[i] = (m != 2'h1);
            digitalIn[i+8] = (m == 2'h0) || (m == 2'h3);
         end else begin
            digitalIn[i] = (m == 2'h0) ? ~rangeSelect : (m != 2'h1);
            digitalIn[i+8] = (m == 2'h3);
         end
      end
      digitalIn[7] = fieldPowerGood;
      digitalIn[15] = spareToggle;
   end
endmodule

// ---- verification/rlm_relay_line_monitor_bench.sv ----
// Self-checking bench: APB register access plus a behavioural field board.
// Assumes short oscillator and power delay parameters to keep the run brief.
`timescale 1ns/1ps
module rlm_relay_line_monitor_bench;
   localparam int unsigned OSC = 8;
   localparam int unsigned PWR = 16;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic fieldPowerGood = 1'h0;
   logic [13:0] faultMode = 14'h0000;
   logic [31:0] prdata;
   logic pready, pslverr, rangeSelect, oscTick, moduleHealthy, resultsValid;
   logic [15:0] digitalIn;
   logic [6:0] relayOut, shortFault, openFault, feedbackMismatch, channelHealthy;
   // Expected values, worked out from the wiring condition of each channel.
   logic [6:0] eRel, eSh, eOp, eMm, eOk;
   logic eValid;
   logic [31:0] rd;
   logic er, rangeBefore;
   int num_errors = 0;
   int total_checks = 0;
   int n;

   // 200 MHz clock.
   always #2.5 clk = ~clk;

   rlm_relay_line_monitor #(.OSC_HALF_CYCLES(OSC), .POWER_DELAY_CYCLES(PWR)) u_dut (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .digitalIn(digitalIn), .relayOut(relayOut),
      .rangeSelect(rangeSelect), .oscTick(oscTick), .shortFault(shortFault),
      .openFault(openFault), .feedbackMismatch(feedbackMismatch),
      .channelHealthy(channelHealthy), .moduleHealthy(moduleHealthy),
      .resultsValid(resultsValid));

   rlm_field_board u_board (
      .clk(clk), .relayOut(relayOut), .rangeSelect(rangeSelect),
      .fieldPowerGood(fieldPowerGood), .faultMode(faultMode), .digitalIn(digitalIn));

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Compares a register word or a port vector.
   task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Compares a single flag.
   task automatic checkBit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge that sees pready high.
   task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      logic ok;
      k = 0;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      // Values read here are those that stood just before this edge.
      do begin
         @(posedge clk);
         k++;
         ok = pready;
      end while (ok !== 1'h1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (ok !== 1'h1) begin
         num_errors++;
         $display("unexpected at %0t: no pready", $time);
         end_of_test();
      end
   endtask

   // Waits for a number of oscillator ticks, with a bound on the cycles.
   task automatic waitTicks(input int cnt);
      int seen;
      int c;
      seen = 0;
      c = 0;
      while (seen < cnt && c < OSC * cnt * 4) begin
         @(negedge clk);
         c++;
         if (oscTick === 1'h1) seen++;
      end
      if (seen < cnt) begin
         num_errors++;
         $display("unexpected at %0t: oscillator stalled", $time);
         end_of_test();
      end
   endtask

   // Steady-state outputs for a given command, in-use mask and wiring.
   task automatic calcExp(input logic [6:0] cmd, input logic [6:0] inUse,
                          input logic [13:0] md, input logic v);
      logic [1:0] m;
      for (int i = 0; i < 7; i++) begin
         m = md[2*i +: 2];
         eRel[i] = cmd[i] && (m != 2'h1);
         eSh[i] = v && !eRel[i] && (m == 2'h1);
         eOp[i] = v && inUse[i] && (eRel[i] ? !(m == 2'h0 || m == 2'h3) : m[1]);
         eMm[i] = v && (eRel[i] ? (m == 2'h1) : (m == 2'h3));
      end
      eOk = {7{v}} & ~(eSh | eOp | eMm);
      eValid = v;
   endtask

   // Reads the three status registers and looks at the pins.
   task automatic checkAll;
      apbXfer(1'h0, rlm_pkg::REG_FAULTS, 32'h00000000);
      checkWord(rd, {9'h000, eMm, 1'h0, eOp, 1'h0, eSh}, "faults");
      apbXfer(1'h0, rlm_pkg::REG_STATUS, 32'h00000000);
      checkWord(rd & 32'h000001FF, {23'h000000, eValid, &eOk, eOk}, "status");
      apbXfer(1'h0, rlm_pkg::REG_RELAYS, 32'h00000000);
      checkWord(rd, {25'h0000000, eRel}, "relays");
      @(negedge clk);
      checkWord({25'h0000000, relayOut}, {25'h0000000, eRel}, "relay pins");
      checkWord({25'h0000000, openFault}, {25'h0000000, eOp}, "open pins");
      checkBit(moduleHealthy, &eOk, "module healthy");
   endtask

   // Applies wiring and control, lets the monitor settle, then checks all.
   task automatic setup(input logic [6:0] cmd, input logic [6:0] inUse,
                        input logic [13:0] md, input logic v);
      @(posedge clk);
      faultMode <= md;
      apbXfer(1'h1, rlm_pkg::REG_CONTROL, {17'h00000, inUse, 1'h0, cmd});
      waitTicks(8);
      calcExp(cmd, inUse, md, v);
      checkAll();
   endtask

   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      calcExp(7'h00, 7'h00, 14'h0000, 1'h0);
      checkAll();
      apbXfer(1'h0, rlm_pkg::REG_CONTROL, 32'h00000000);
      checkWord(rd, 32'h00000000, "control reset");
      apbXfer(1'h1, 12'h010, 32'hFFFFFFFF);
      checkBit(er, 1'h1, "unmapped write");
      apbXfer(1'h0, 12'h010, 32'h00000000);
      checkBit(er, 1'h1, "unmapped read");
      checkWord(rd, 32'h00000000, "unmapped data");
      // Read-only places must swallow writes without touching control.
      apbXfer(1'h1, rlm_pkg::REG_STATUS, 32'hFFFFFFFF);
      apbXfer(1'h0, rlm_pkg::REG_CONTROL, 32'h00000000);
      checkBit(er, 1'h0, "control error");
      checkWord(rd, 32'h00000000, "control kept");
      // Faulty wiring without field power: nothing may be reported.
      setup(7'h00, 7'h6F, 14'h02E4, 1'h0);
      waitTicks(1);
      rangeBefore = rangeSelect;
      @(negedge clk);
      checkBit(rangeSelect, ~rangeBefore, "range flip");
      @(posedge clk);
      fieldPowerGood <= 1'h1;
      n = 0;
      while (resultsValid !== 1'h1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (resultsValid !== 1'h1) begin
         num_errors++;
         $display("unexpected at %0t: results never valid", $time);
         end_of_test();
      end
      checkBit((n >= PWR) && (n <= PWR + 3), 1'h1, "power delay");
      setup(7'h00, 7'h6F, 14'h02E4, 1'h1);
      setup(7'h7F, 7'h6F, 14'h02E4, 1'h1);
      // Clean wiring: the short clears and the relays follow the command.
      setup(7'h2A, 7'h7F, 14'h0000, 1'h1);
      @(posedge clk);
      fieldPowerGood <= 1'h0;
      repeat (3) @(negedge clk);
      checkBit(resultsValid, 1'h0, "power lost");
      calcExp(7'h2A, 7'h7F, 14'h0000, 1'h0);
      checkAll();
      end_of_test();
   end
endmodule
